/* bench/test_protocol_state_command_control.sv */
/*
 * Self-checking bench of the protocol state command control: walks the
 * state commands, the unlock sequence, the busy window and the buffer checks.
 * Assumes the proto_ctrl register map and the AXI4-Lite timing of its notes.
 */
`timescale 1ns/1ps
module test_protocol_state_command_control;
  import proto_ctrl_pkg::*;
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic wake_end, start_done, awready, wready, bvalid, arready, rvalid;
  logic busy, clr_we;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [5:0] state;
  logic [10:0] clr_addr;
  int n_errors, n_checks, busy_cyc;

  proto_ctrl proto_ctrl_i (.CORE_CLK(clk), .RESET_N(rst_n),
    .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
    .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
    .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
    .RREADY(rready), .WAKEUP_END(wake_end), .STARTUP_DONE(start_done),
    .PROTOCOL_STATE(state), .PROTOCOL_BUSY(busy),
    .RAM_CLR_ADDR(clr_addr), .RAM_CLR_WE(clr_we));

  // The clock runs at 40 MHz.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Counts the cycles spent clearing after a reset release.
  always @(posedge clk) begin
    if (rst_n === 1'b1 && busy === 1'b1) busy_cyc++;
  end

  task automatic complete_run;
    if (n_errors == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk_word(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_resp(input string nm, input logic [1:0] e, g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Offers address and data together and waits for the response.
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           output logic [1:0] r);
    int n;
    logic aw_done, w_done;
    n = 0;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(aw_done && w_done) && n < 50);
    do begin
      @(posedge clk);
      n++;
    end while (bvalid !== 1'b1 && n < 50);
    r = bresp;
    if (n >= 50) chk_word("bus_write_timeout", 32'h0000_0000, 32'h0000_0001);
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (arready !== 1'b1 && n < 50);
    arvalid <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (rvalid !== 1'b1 && n < 50);
    d = rdata;
    r = rresp;
    if (n >= 50) chk_word("bus_read_timeout", 32'h0000_0000, 32'h0000_0001);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    chk_resp("bresp", RESP_OKAY, r);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    chk_resp("rresp", RESP_OKAY, r);
    chk_word(nm, e, d);
  endtask

  // Writes a command and checks the state once it has landed.
  task automatic cmd(input logic [3:0] c, input logic [5:0] e);
    wr(ADDR_CTRL, {28'h000_0000, c});
    repeat (2) @(posedge clk);
    chk_word("state", {26'h000_0000, e}, {26'h000_0000, state});
  endtask

  // Hang guard, well beyond the roughly 2200 cycles the tests need.
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    complete_run();
  end

  // Main sequence.
  initial begin
    static logic [7:0] t_idx [5] = '{8'h00, 8'h01, 8'h02, 8'h07, 8'h08};
    static logic [6:0] t_len [5] = '{7'h02, 7'h00, 7'h03, 7'h04, 7'h04};
    static logic [10:0] t_ptr [5] = '{11'h44C, 11'h020, 11'h7C1, 11'h055,
                                      11'h01F};
    logic [1:0] kind, r;
    logic [31:0] d;
    rst_n = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    bready = 1'b1;
    rready = 1'b1;
    wstrb = 4'hF;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wake_end = 1'b0;
    start_done = 1'b0;
    n_errors = 0;
    n_checks = 0;
    busy_cyc = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk_word("state_rst", 32'h0000_0001, {26'h000_0000, state});
    chk_word("busy_rst", 32'h0000_0001, {31'h0, busy});
    chk_word("clr_we", 32'h0000_0001, {31'h0, clr_we});
    chk_word("clr_addr", 32'h0000_0000, {21'h00_0000, clr_addr});
    wr(ADDR_CTRL, {28'h000_0000, CMD_CONFIG});
    wr(ADDR_PART, 32'h0004_0207);
    rd_chk("part_busy", ADDR_PART, 32'h0180_8000);
    chk_word("state_busy", 32'h0000_0001, {26'h000_0000, state});
    while (busy !== 1'b0 && busy_cyc < 2100) @(posedge clk);
    chk_word("busy_len", 32'h0000_0800, busy_cyc);
    chk_word("clr_we_end", 32'h0000_0000, {31'h0, clr_we});
    cmd(CMD_CONFIG, ST_CONFIG);
    wr(ADDR_PART, 32'h0004_0207);
    rd_chk("part", ADDR_PART, 32'h0804_0207);
    wr(ADDR_HCFG, 32'h0000_0002);
    rd_chk("hcfg", ADDR_HCFG, 32'h0004_0002);
    // Buffer checks against last 7, first dynamic 2, first FIFO 4.
    for (int i = 0; i < 5; i++) begin
      kind = (t_idx[i] < 8'h02) ? KIND_STATIC :
             (t_idx[i] >= 8'h04 && t_idx[i] <= 8'h07) ? KIND_FIFO :
             KIND_DYNAMIC;
      wr(ADDR_HCHK, {t_idx[i], 1'b0, t_len[i], 5'h00, t_ptr[i]});
      rd_chk("hres", ADDR_HRES, {16'h0000, t_len[i], 1'b0, 4'h0, kind,
             t_idx[i] <= 8'h07, t_ptr[i] >= 11'h020});
      rd_chk("hadr", ADDR_HADR, {3'h0, t_ptr[i], 2'h0, 4'h0, t_idx[i],
             4'h0});
    end
    cmd(CMD_READY, ST_CONFIG);
    rd_chk("ctrl", ADDR_CTRL, 32'h0002_0200);
    cmd(CMD_WAKEUP, ST_CONFIG);
    wr(ADDR_LOCK, {24'h00_0000, LOCK_KEY_FIRST});
    rd_chk("lock", ADDR_LOCK, 32'h0000_0000);
    wr(ADDR_LOCK, {24'h00_0000, LOCK_KEY_SECOND});
    cmd(CMD_READY, ST_CONFIG);
    wr(ADDR_LOCK, {24'h00_0000, LOCK_KEY_FIRST});
    wr(ADDR_LOCK, {24'h00_0000, LOCK_KEY_SECOND});
    cmd(CMD_READY, ST_READY);
    cmd(CMD_CONFIG, ST_READY);
    cmd(CMD_WAKEUP, ST_WAKEUP);
    wake_end <= 1'b1;
    @(posedge clk);
    wake_end <= 1'b0;
    repeat (2) @(posedge clk);
    chk_word("wake_end", 32'h0000_0004, {26'h000_0000, state});
    cmd(CMD_WAKEUP, ST_WAKEUP);
    cmd(CMD_READY, ST_READY);
    cmd(CMD_RUN, ST_STARTUP);
    cmd(CMD_READY, ST_READY);
    cmd(CMD_RUN, ST_STARTUP);
    start_done <= 1'b1;
    @(posedge clk);
    start_done <= 1'b0;
    repeat (2) @(posedge clk);
    chk_word("start_ok", 32'h0000_0020, {26'h000_0000, state});
    cmd(CMD_RUN, ST_NORMAL_ACTIVE);
    cmd(CMD_READY, ST_READY);
    // Unmapped place answers with an error and zero data.
    axi_write(8'h1C, 32'h0000_0001, r);
    chk_resp("bresp_unmapped", RESP_SLVERR, r);
    axi_read(8'h1C, d, r);
    chk_resp("rresp_unmapped", RESP_SLVERR, r);
    chk_word("rdata_unmapped", 32'h0000_0000, d);
    // A reset in mid-run returns to default configuration and clears again.
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk_word("state_rst2", 32'h0000_0001, {26'h000_0000, state});
    chk_word("busy_rst2", 32'h0000_0001, {31'h0, busy});
    rst_n <= 1'b1;
    @(posedge clk);
    chk_word("clr_addr2", 32'h0000_0000, {21'h00_0000, clr_addr});
    cmd(CMD_CONFIG, ST_DEFAULT_CONFIG);
    chk_word("clr_we2", 32'h0000_0001, {31'h0, clr_we});
    complete_run();
  end
endmodule

/* rtl/proto_ctrl.sv */
/*
 * Protocol state command control with buffer partition checks, reached
 * over AXI4-Lite. Assumes the protocol engine pulses WAKEUP_END and
 * STARTUP_DONE on CORE_CLK, and a RAM that takes clear writes.
 */
// The register offsets and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
module proto_ctrl
  import proto_ctrl_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic WAKEUP_END,
  input wire logic STARTUP_DONE,
  output logic [5:0] PROTOCOL_STATE,
  output logic PROTOCOL_BUSY,
  output logic [10:0] RAM_CLR_ADDR,
  output logic RAM_CLR_WE
);

  poc_state_t state_r, state_nxt;
  part_cfg_t part_r;
  hdr_chk_t hchk_r;
  logic [6:0] spl_r;
  logic busy_r, armed_r, unlocked_r, refused_r;
  logic [10:0] clr_addr_r;
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;

  // Byte-lane merge for partial writes.
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Bus handshakes and write decode.
  wire wr_fire = AWVALID && awready_r && WVALID && wready_r;
  wire rd_fire = ARVALID && arready_r;
  wire any_fire = wr_fire || rd_fire;
  wire wr_ctrl = wr_fire && AWADDR == ADDR_CTRL && WSTRB[0];
  wire wr_lock = wr_fire && AWADDR == ADDR_LOCK && WSTRB[0];
  wire cfg_ok = !busy_r &&
                (state_r == ST_DEFAULT_CONFIG || state_r == ST_CONFIG);
  wire wr_part = wr_fire && AWADDR == ADDR_PART && cfg_ok;
  wire wr_hcfg = wr_fire && AWADDR == ADDR_HCFG && cfg_ok;
  wire wr_hchk = wr_fire && AWADDR == ADDR_HCHK;
  wire wr_map = AWADDR == ADDR_CTRL || AWADDR == ADDR_LOCK ||
                AWADDR == ADDR_PART || AWADDR == ADDR_HCFG ||
                AWADDR == ADDR_HCHK;
  wire [3:0] cmd = WDATA[3:0];
  wire cmd_fire = wr_ctrl && !busy_r;
  wire key_first = wr_lock && WDATA[7:0] == LOCK_KEY_FIRST;
  wire key_second = wr_lock && WDATA[7:0] == LOCK_KEY_SECOND;

  // Buffer partition checks on the staged header values.
  wire [7:0] last_buf = part_r.last_configured_buffer;
  wire [7:0] first_dyn = part_r.first_dynamic_buffer;
  wire [7:0] first_fifo = part_r.first_fifo_buffer;
  wire [10:0] data_ptr = hchk_r.buffer_data_pointer;
  wire [6:0] pay_len = hchk_r.buffer_payload_length;
  wire [12:0] min_pointer = ({5'h00, last_buf} + 13'h0001) << WORD_SHIFT;
  wire pointer_ok = {2'b00, data_ptr} >= min_pointer;
  wire in_use = hchk_r.idx <= last_buf;
  wire is_static = hchk_r.idx < first_dyn;
  wire is_fifo = hchk_r.idx >= first_fifo && in_use;
  wire [1:0] kind = is_static ? KIND_STATIC :
                    (is_fifo ? KIND_FIFO : KIND_DYNAMIC);
  wire [7:0] payload_bytes = {pay_len, 1'b0};
  wire [7:0] spl_bytes = {spl_r, 1'b0};
  wire [8:0] buf_count = {1'b0, last_buf} + 9'h001;
  wire [12:0] hdr_addr = {1'b0, hchk_r.idx, 4'h0};
  wire [12:0] data_addr = {data_ptr, 2'b00};

  // Read data selection.
  wire [31:0] rd_ctrl = (32'(unlocked_r) << CTRL_UNLOCKED_BIT) |
                        (32'(refused_r) << CTRL_REFUSED_BIT) |
                        (32'(busy_r) << CTRL_BUSY_BIT) |
                        (32'(state_r) << CTRL_STATE_LSB);
  wire [31:0] rd_part = (32'(buf_count[7:0]) << PART_COUNT_LSB) |
                        (32'(first_fifo) << PART_FIRST_FIFO_LSB) |
                        (32'(first_dyn) << PART_FIRST_DYN_LSB) |
                        32'(last_buf);
  wire [31:0] rd_hcfg = (32'(spl_bytes) << HCFG_BYTES_LSB) | 32'(spl_r);
  wire [31:0] rd_hchk = (32'(hchk_r.idx) << HCHK_IDX_LSB) |
                        (32'(pay_len) << HCHK_PAYLOAD_LSB) |
                        32'(data_ptr);
  wire [31:0] rd_hres = (32'(payload_bytes) << HRES_BYTES_LSB) |
                        (32'(kind) << HRES_KIND_LSB) |
                        {30'h0000_0000, in_use, pointer_ok};
  wire [31:0] rd_hadr = (32'(data_addr) << HADR_DATA_LSB) | 32'(hdr_addr);
  wire rd_map = ARADDR == ADDR_CTRL || ARADDR == ADDR_LOCK ||
                ARADDR == ADDR_PART || ARADDR == ADDR_HCFG ||
                ARADDR == ADDR_HCHK || ARADDR == ADDR_HRES ||
                ARADDR == ADDR_HADR;
  wire [31:0] rd_mux = ARADDR == ADDR_CTRL ? rd_ctrl :
                       ARADDR == ADDR_PART ? rd_part :
                       ARADDR == ADDR_HCFG ? rd_hcfg :
                       ARADDR == ADDR_HCHK ? rd_hchk :
                       ARADDR == ADDR_HRES ? rd_hres :
                       ARADDR == ADDR_HADR ? rd_hadr : 32'h0000_0000;

  // Next protocol state from commands and engine events.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_DEFAULT_CONFIG: begin
        if (cmd_fire && cmd == CMD_CONFIG) begin
          state_nxt = ST_CONFIG;
        end
      end
      ST_CONFIG: begin
        if (cmd_fire && cmd == CMD_READY && unlocked_r) begin
          state_nxt = ST_READY;
        end
      end
      ST_READY: begin
        if (cmd_fire && cmd == CMD_WAKEUP) begin
          state_nxt = ST_WAKEUP;
        end else if (cmd_fire && cmd == CMD_RUN) begin
          state_nxt = ST_STARTUP;
        end
      end
      ST_WAKEUP: begin
        if ((cmd_fire && cmd == CMD_READY) || WAKEUP_END) begin
          state_nxt = ST_READY;
        end
      end
      ST_STARTUP: begin
        if (cmd_fire && cmd == CMD_READY) begin
          state_nxt = ST_READY;
        end else if (STARTUP_DONE) begin
          state_nxt = ST_NORMAL_ACTIVE;
        end
      end
      ST_NORMAL_ACTIVE: begin
        if (cmd_fire && cmd == CMD_READY) begin
          state_nxt = ST_READY;
        end
      end
      default: begin
        state_nxt = ST_DEFAULT_CONFIG;
      end
    endcase
  end

  wire cmd_taken = cmd_fire && state_nxt != state_r;

  // Protocol state and refused-command flag.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_r <= ST_DEFAULT_CONFIG;
      refused_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (cmd_fire) begin
        refused_r <= !cmd_taken;
      end
    end
  end

  // Two-write unlock; any access after the first key ends the attempt.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      armed_r <= 1'b0;
      unlocked_r <= 1'b0;
    end else if (state_r != ST_CONFIG) begin
      armed_r <= 1'b0;
      unlocked_r <= 1'b0;
    end else if (armed_r && any_fire) begin
      armed_r <= 1'b0;
      unlocked_r <= key_second;
    end else if (key_first) begin
      armed_r <= 1'b1;
    end
  end

  // Message RAM clearing after reset with the busy flag held high.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      busy_r <= 1'b1;
      clr_addr_r <= 11'h000;
    end else if (busy_r) begin
      clr_addr_r <= clr_addr_r + 11'h001;
      if (clr_addr_r == CLEAR_LAST) begin
        busy_r <= 1'b0;
      end
    end
  end

  // Incoming write words merged with the present contents by byte lane.
  wire [31:0] part_wr = merge(32'(part_r), WDATA, WSTRB);
  wire [31:0] hcfg_wr = merge(32'(spl_r), WDATA, WSTRB);
  wire [31:0] hchk_wr = merge(rd_hchk, WDATA, WSTRB);

  // Configuration registers.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      part_r <= '{first_fifo_buffer: FIRST_FIFO_RESET,
                  first_dynamic_buffer: FIRST_DYN_RESET,
                  last_configured_buffer: LAST_BUF_RESET};
      spl_r <= 7'h00;
      hchk_r <= '0;
    end else begin
      if (wr_part) begin
        part_r <= part_wr[23:0];
      end
      if (wr_hcfg) begin
        spl_r <= hcfg_wr[6:0];
      end
      if (wr_hchk) begin
        hchk_r <= {hchk_wr[31:24], hchk_wr[22:16], hchk_wr[10:0]};
      end
    end
  end

  // AXI4-Lite write channel: both address and data are taken together.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      awready_r <= AWVALID && WVALID && !awready_r && !bvalid_r;
      wready_r <= AWVALID && WVALID && !awready_r && !bvalid_r;
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (BREADY) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else begin
      arready_r <= ARVALID && !arready_r && !rvalid_r;
      if (rd_fire) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_mux;
        rresp_r <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end else if (RREADY) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // Outputs straight from flip-flops.
  assign AWREADY = awready_r;
  assign WREADY = wready_r;
  assign BVALID = bvalid_r;
  assign BRESP = bresp_r;
  assign ARREADY = arready_r;
  assign RVALID = rvalid_r;
  assign RDATA = rdata_r;
  assign RRESP = rresp_r;
  assign PROTOCOL_STATE = state_r;
  assign PROTOCOL_BUSY = busy_r;
  assign RAM_CLR_ADDR = clr_addr_r;
  assign RAM_CLR_WE = busy_r;

  // Checks on the state machine, unlock and partition logic.
  property p_busy_default;
    @(posedge CORE_CLK) disable iff (!RESET_N)
    busy_r |-> state_r == ST_DEFAULT_CONFIG;
  endproperty
  a_busy_default: assert property (p_busy_default)
    else $error("state left default configuration while busy");

  property p_config_cmd;
    @(posedge CORE_CLK) disable iff (!RESET_N)
    state_r == ST_DEFAULT_CONFIG && cmd_fire && cmd == CMD_CONFIG
      |=> state_r == ST_CONFIG;
  endproperty
  a_config_cmd: assert property (p_config_cmd)
    else $error("config command did not enter configuration");

  property p_ready_unlock;
    @(posedge CORE_CLK) disable iff (!RESET_N)
    $rose(state_r == ST_READY) && $past(state_r) == ST_CONFIG
      |-> $past(unlocked_r) && $past(cmd_fire);
  endproperty
  a_ready_unlock: assert property (p_ready_unlock)
    else $error("left configuration without unlock");

  property p_locked_refuse;
    @(posedge CORE_CLK) disable iff (!RESET_N)
    state_r == ST_CONFIG && cmd_fire && !unlocked_r
      |=> state_r == ST_CONFIG ##0 refused_r;
  endproperty
  a_locked_refuse: assert property (p_locked_refuse)
    else $error("locked configuration accepted a command");

  property p_wakeup;
    @(posedge CORE_CLK) disable iff (!RESET_N)
    state_r == ST_READY && cmd_fire && cmd == CMD_WAKEUP
      |=> state_r == ST_WAKEUP;
  endproperty
  a_wakeup: assert property (p_wakeup)
    else $error("wakeup command not taken");

  property p_wakeup_end;
    @(posedge CORE_CLK) disable iff (!RESET_N)
    state_r == ST_WAKEUP && WAKEUP_END |=> state_r == ST_READY;
  endproperty
  a_wakeup_end: assert property (p_wakeup_end)
    else $error("wakeup end did not return to ready");

  property p_run;
    @(posedge CORE_CLK) disable iff (!RESET_N)
    state_r == ST_READY && cmd_fire && cmd == CMD_RUN
      |=> state_r == ST_STARTUP;
  endproperty
  a_run: assert property (p_run)
    else $error("run command not taken");

  property p_startup_done;
    @(posedge CORE_CLK) disable iff (!RESET_N)
    state_r == ST_STARTUP && STARTUP_DONE && !cmd_fire
      |=> state_r == ST_NORMAL_ACTIVE;
  endproperty
  a_startup_done: assert property (p_startup_done)
    else $error("startup success did not reach normal active");

  property p_back_ready;
    @(posedge CORE_CLK) disable iff (!RESET_N)
    (state_r == ST_STARTUP || state_r == ST_NORMAL_ACTIVE) && cmd_fire &&
      cmd == CMD_READY |=> state_r == ST_READY;
  endproperty
  a_back_ready: assert property (p_back_ready)
    else $error("ready command did not return to ready");

  property p_unlock_order;
    @(posedge CORE_CLK) disable iff (!RESET_N)
    $rose(unlocked_r) |-> $past(armed_r) && $past(key_second);
  endproperty
  a_unlock_order: assert property (p_unlock_order)
    else $error("unlock without two consecutive key writes");

  property p_busy_len;
    @(posedge CORE_CLK) disable iff (!RESET_N)
    $fell(busy_r) |-> $past(clr_addr_r) == CLEAR_LAST;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("busy dropped before the whole RAM was cleared");

  property p_hold;
    @(posedge CORE_CLK) disable iff (!RESET_N)
    !cmd_fire && !WAKEUP_END && !STARTUP_DONE |=> $stable(state_r);
  endproperty
  a_hold: assert property (p_hold)
    else $error("state changed with no cause");

  property p_addr_math;
    @(posedge CORE_CLK) disable iff (!RESET_N)
    hdr_addr[3:0] == 4'h0 && data_addr[1:0] == 2'b00 &&
      payload_bytes == 8'(pay_len * 2);
  endproperty
  a_addr_math: assert property (p_addr_math)
    else $error("buffer address or length scaling wrong");

  c_normal: cover property (@(posedge CORE_CLK) disable iff (!RESET_N)
    state_r == ST_STARTUP ##1 state_r == ST_NORMAL_ACTIVE);
  c_unlock: cover property (@(posedge CORE_CLK) disable iff (!RESET_N)
    $rose(unlocked_r));
  c_refused: cover property (@(posedge CORE_CLK) disable iff (!RESET_N)
    $rose(refused_r));
  c_wake: cover property (@(posedge CORE_CLK) disable iff (!RESET_N)
    state_r == ST_WAKEUP ##1 state_r == ST_READY);

endmodule

/* rtl/proto_ctrl_pkg.sv */
/*
 * Constants, types and register map of the protocol state command control.
 * Assumes a 32-bit AXI4-Lite master and a 2048-word message RAM clearer.
 */
// How it works
// - Any reset puts the controller in default configuration until a config command after the clear.
// - Command 0001 in default configuration enters configuration once the busy flag is low.
// - Configuration goes to ready on command 0010 only after unlocking.
// - Command 0011 in ready enters wakeup.
// - Wakeup returns to ready on command 0010 or wakeup end.
// - Run command 0100 in ready enters startup.
// - Startup enters normal active by itself on startup success.
// - Command 0010 from startup or normal active returns to ready.
// - Commands leaving configuration are refused without prior unlock.
// - Any access between the two unlock writes discards the partial unlock.
// - After reset the message RAM is cleared while the busy flag is high.
// - Last configured buffer holds buffer count minus one.
// - Static payload length counts two-byte words.
// - Buffer payload length code counts two-byte words.
// - Below first dynamic is static; first FIFO to last buffer is FIFO.
// - Data pointer addresses four-byte words from buffer 0.
// - Each buffer owns a fixed 16-byte header.
package proto_ctrl_pkg;

  // Byte offsets of the registers.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_LOCK = 8'h04;
  localparam logic [7:0] ADDR_PART = 8'h08;
  localparam logic [7:0] ADDR_HCFG = 8'h0C;
  localparam logic [7:0] ADDR_HCHK = 8'h10;
  localparam logic [7:0] ADDR_HRES = 8'h14;
  localparam logic [7:0] ADDR_HADR = 8'h18;

  // Command codes.
  localparam logic [3:0] CMD_CONFIG = 4'h1;
  localparam logic [3:0] CMD_READY = 4'h2;
  localparam logic [3:0] CMD_WAKEUP = 4'h3;
  localparam logic [3:0] CMD_RUN = 4'h4;

  // Unlock keys; the values are arbitrary.
  localparam logic [7:0] LOCK_KEY_FIRST = 8'hA5;
  localparam logic [7:0] LOCK_KEY_SECOND = 8'h5A;

  // Field positions.
  localparam int CTRL_STATE_LSB = 8;
  localparam int CTRL_BUSY_BIT = 16;
  localparam int CTRL_REFUSED_BIT = 17;
  localparam int CTRL_UNLOCKED_BIT = 18;
  localparam int PART_FIRST_DYN_LSB = 8;
  localparam int PART_FIRST_FIFO_LSB = 16;
  localparam int PART_COUNT_LSB = 24;
  localparam int HCFG_BYTES_LSB = 16;
  localparam int HCHK_PAYLOAD_LSB = 16;
  localparam int HCHK_IDX_LSB = 24;
  localparam int HRES_KIND_LSB = 2;
  localparam int HRES_BYTES_LSB = 8;
  localparam int HADR_DATA_LSB = 16;

  // Reset values of the partition boundaries.
  localparam logic [7:0] LAST_BUF_RESET = 8'h00;
  localparam logic [7:0] FIRST_DYN_RESET = 8'h80;
  localparam logic [7:0] FIRST_FIFO_RESET = 8'h80;

  // Message RAM geometry and clearing count.
  localparam int HDR_SHIFT = 4;
  localparam int WORD_SHIFT = 2;
  localparam int CLEAR_WORDS = 2048;
  localparam logic [10:0] CLEAR_LAST = 11'(CLEAR_WORDS - 1);

  // Buffer kinds.
  localparam logic [1:0] KIND_STATIC = 2'h0;
  localparam logic [1:0] KIND_DYNAMIC = 2'h1;
  localparam logic [1:0] KIND_FIFO = 2'h2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [5:0] {
    ST_DEFAULT_CONFIG = 6'b000001,
    ST_CONFIG = 6'b000010,
    ST_READY = 6'b000100,
    ST_WAKEUP = 6'b001000,
    ST_STARTUP = 6'b010000,
    ST_NORMAL_ACTIVE = 6'b100000
  } poc_state_t;

  typedef struct packed {
    logic [7:0] first_fifo_buffer;
    logic [7:0] first_dynamic_buffer;
    logic [7:0] last_configured_buffer;
  } part_cfg_t;

  typedef struct packed {
    logic [7:0] idx;
    logic [6:0] buffer_payload_length;
    logic [10:0] buffer_data_pointer;
  } hdr_chk_t;

endpackage
